// ==== hw/pct_pkg.sv ====
package pct_pkg;

  // =====================================================================
  // register offsets (byte addresses of the configuration page)
  // =====================================================================
  localparam logic [5:0] OFS_HEADER    = 6'h00;
  localparam logic [5:0] OFS_LENGTH    = 6'h01;
  localparam logic [5:0] OFS_PRECED    = 6'h02;
  localparam logic [5:0] OFS_TMR_EN    = 6'h03;
  localparam logic [5:0] OFS_IDLE1     = 6'h04;
  localparam logic [5:0] OFS_STBY_SHAL = 6'h08;
  localparam logic [5:0] OFS_IDLE2     = 6'h0c;
  localparam logic [5:0] OFS_IDLE3     = 6'h10;
  localparam logic [5:0] OFS_STBY_DEEP = 6'h14;
  localparam logic [5:0] OFS_POLICY    = 6'h27;
  // block-local registers placed in the reserved gap
  localparam logic [5:0] OFS_IRQ_STAT  = 6'h18;
  localparam logic [5:0] OFS_IRQ_EN    = 6'h1c;
  localparam logic [5:0] OFS_IRQ_CLR   = 6'h20;
  localparam logic [5:0] OFS_UNLOADS   = 6'h24;

  // =====================================================================
  // reset values
  // =====================================================================
  localparam logic [7:0]  RST_HEADER = 8'h1a;
  localparam logic [7:0]  RST_LENGTH = 8'h26;
  localparam logic [7:0]  RST_PRECED = 8'h00;
  localparam logic [7:0]  RST_TMR_EN = 8'h06;
  localparam logic [31:0] RST_IDLE1  = 32'h0000_0014;
  localparam logic [31:0] RST_SHAL   = 32'h0000_0000;
  localparam logic [31:0] RST_IDLE2  = 32'h0000_1770;
  localparam logic [31:0] RST_IDLE3  = 32'h0000_0000;
  localparam logic [31:0] RST_DEEP   = 32'h0000_0000;
  localparam logic [7:0]  RST_POLICY = 8'h58;

  // =====================================================================
  // field positions
  // =====================================================================
  localparam int POS_SAVABLE = 7;   // header: savable flag
  localparam int POS_PREC    = 6;   // precedence field bits 7:6
  localparam int POS_DEEP_EN = 0;   // deep standby enable in byte 2
  localparam int POS_IDLE3_EN = 3;  // byte 3 enables
  localparam int POS_IDLE2_EN = 2;
  localparam int POS_IDLE1_EN = 1;
  localparam int POS_SHAL_EN  = 0;
  localparam int POS_REPORT_AFTER_IDLE_EXIT = 6;  // policy byte fields, two bits each
  localparam int POS_CCF_STBY = 4;
  localparam int POS_CCF_STOP = 2;

  // =====================================================================
  // timing counts
  // =====================================================================
  localparam int  CLK_HZ      = 250_000_000;
  localparam int  TICK_MS     = 100;                        // timer unit
  localparam int  TICK_CYC    = CLK_HZ / 1000 * TICK_MS;    // 25,000,000
  localparam logic [31:0] MIN_IDLE1_TICKS = 32'h0000_000a;  // 1 s
  localparam logic [31:0] MIN_OTHER_TICKS = 32'h0000_04b0;  // 2 min
  localparam logic [6:0]  MAX_UNLOADS     = 7'h3c;          // 60 per window
  localparam int  WINDOW_HOURS = 24;
  localparam longint WINDOW_TICKS = longint'(WINDOW_HOURS) * 3600 * 10;

  // =====================================================================
  // encodings and types
  // =====================================================================
  localparam logic [1:0] CCF_OFF = 2'h1;  // do not report
  localparam logic [1:0] CCF_ON  = 2'h2;  // report
  localparam logic [1:0] PREC_BG = 2'h1;  // background first
  localparam logic [1:0] PREC_LP = 2'h2;  // low power first
  localparam int NUM_TMR = 5;

  // timer index order: 0 idle1, 1 idle2, 2 idle3, 3 shallow, 4 deep
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [31:0] wdata;
  } pct_bus_s;

  typedef struct packed {
    logic report_idle;   // check status after idle exit
    logic report_stby;   // after standby exit
    logic report_stop;   // after stop exit
  } pct_ccf_s;

  typedef enum logic [2:0] {
    PW_ACTIVE = 3'b001,
    PW_LOW    = 3'b010,
    PW_BG     = 3'b100
  } pct_pw_e;

endpackage : pct_pkg

// ==== hw/pct_tick.sv ====
`timescale 1ns/1ps
// =====================================================================
// 100 ms tick prescaler
// =====================================================================
module pct_tick
  import pct_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // tick
  output logic      tick
);
  logic [24:0] cnt;  // cycle counter within one unit

  // free-running divide to one pulse per unit
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt  <= 25'h0;
      tick <= 1'b0;
    end else if (cnt == 25'(TICK_CYC - 1)) begin
      cnt  <= 25'h0;
      tick <= 1'b1;
    end else begin
      cnt  <= cnt + 25'h1;
      tick <= 1'b0;
    end
  end
endmodule : pct_tick

// ==== hw/pct_timer.sv ====
`timescale 1ns/1ps
// =====================================================================
// one inactivity timer with clamp
// =====================================================================
module pct_timer
  import pct_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // control
  input  wire logic        enable,
  input  wire logic [31:0] init_val,
  input  wire logic [31:0] min_val,
  input  wire logic        activity,
  input  wire logic        tick,
  // result
  output logic             expire
);
  logic [31:0] remain;     // ticks left
  logic        armed;      // counting toward expiry
  logic [31:0] eff;        // clamped initial value

  // short settings are accepted but raised to the minimum
  assign eff = (init_val < min_val) ? min_val : init_val;

  // reload on activity, count on tick, pulse once at zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      remain <= 32'h0;
      armed  <= 1'b0;
      expire <= 1'b0;
    end else if (!enable) begin  // disabled timer is ignored
      armed  <= 1'b0;
      expire <= 1'b0;
    end else if (activity || !armed) begin  // reload
      remain <= eff;
      armed  <= 1'b1;
      expire <= 1'b0;
    end else if (tick && remain != 32'h0) begin
      remain <= remain - 32'h1;
      expire <= (remain == 32'h1);
    end else begin
      expire <= 1'b0;
    end
  end
endmodule : pct_timer

// ==== hw/pct_top.sv ====
`timescale 1ns/1ps
// Overview of operation
// - timer runs only while its enable set
// - timer values count 100 ms units
// - first idle below 1 s becomes 1 s
// - other timers below 2 min become 2 min
// - at most 60 timer unloads per 24 h
// - idle report field: 01 off, 10 on
// - standby report field: 01 off, 10 on
// - stopped report field: 01 off, 10 on
// - code 01: background wakes, finishes before transition
// - code 10: stay low, suspend background on expiry
module pct_top
  import pct_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // register port
  input  wire logic [5:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // unit activity and background
  input  wire logic        host_activity,
  input  wire logic        bg_request,
  input  wire logic        bg_done,
  input  wire logic        power_exit_idle,
  input  wire logic        power_exit_stby,
  input  wire logic        power_exit_stop,
  // power requests
  output logic [4:0]       enter_request,
  output logic             head_unload,
  output logic             bg_run,
  output logic             bg_suspend,
  output logic             check_condition,
  output pct_ccf_s         ccf_policy,
  // interrupt
  output logic             irq
);
  // =====================================================================
  // configuration registers
  // =====================================================================
  logic        savable;       // header savable flag
  logic [7:0]  preced;        // precedence and deep standby enable
  logic [7:0]  tmr_en;        // timer enable byte
  logic [31:0] tval [NUM_TMR];// timer initial values
  logic [7:0]  policy;        // check condition policy byte
  logic [2:0]  irq_stat;      // sticky events
  logic [2:0]  irq_en;        // event enables
  logic        tick;          // 100 ms unit
  logic [4:0]  en_vec;        // per timer enable
  logic [4:0]  expire;        // per timer expiry pulse
  logic [6:0]  unloads;       // timer unloads in window
  logic [31:0] win_cnt;       // ticks into window
  pct_pw_e     pw;            // power state
  logic        unload_ok;     // budget remains
  logic        any_exp;       // some timer expired
  logic [1:0]  prec;          // precedence code
  logic [2:0]  ev;            // events: expiry, unload denied, check
  logic [2:0]  irq_clr;       // write-one clear
  logic [4:0]  pend_exp;      // expiries held back while background runs

  assign prec = preced[POS_PREC +: 2];
  assign en_vec = {preced[POS_DEEP_EN], tmr_en[POS_SHAL_EN], tmr_en[POS_IDLE3_EN],
                   tmr_en[POS_IDLE2_EN], tmr_en[POS_IDLE1_EN]};

  // =====================================================================
  // register writes
  // =====================================================================
  // software-writable bytes; length byte is fixed
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      savable <= RST_HEADER[POS_SAVABLE];
      preced  <= RST_PRECED;
      tmr_en  <= RST_TMR_EN;
      tval[0] <= RST_IDLE1;
      tval[1] <= RST_IDLE2;
      tval[2] <= RST_IDLE3;
      tval[3] <= RST_SHAL;
      tval[4] <= RST_DEEP;
      policy  <= RST_POLICY;
      irq_en  <= 3'h0;
    end else if (reg_wr) begin
      unique case (reg_addr)
        OFS_HEADER:    savable <= reg_wdata[POS_SAVABLE];
        // reserved bits of byte 2 read back as zero
        OFS_PRECED:    preced  <= {reg_wdata[7:6], 5'h0, reg_wdata[0]};
        OFS_TMR_EN:    tmr_en  <= {4'h0, reg_wdata[3:0]};
        OFS_IDLE1:     tval[0] <= reg_wdata;
        OFS_IDLE2:     tval[1] <= reg_wdata;
        OFS_IDLE3:     tval[2] <= reg_wdata;
        OFS_STBY_SHAL: tval[3] <= reg_wdata;
        OFS_STBY_DEEP: tval[4] <= reg_wdata;
        OFS_POLICY:    policy  <= {reg_wdata[7:2], 2'h0};
        OFS_IRQ_EN:    irq_en  <= reg_wdata[2:0];
        default:       ;  // unmapped or read-only: ignored
      endcase
    end
  end

  // =====================================================================
  // read port, data one cycle after strobe
  // =====================================================================
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        OFS_HEADER:    reg_rdata <= {24'h0, savable, RST_HEADER[6:0]};
        OFS_LENGTH:    reg_rdata <= {24'h0, RST_LENGTH};
        OFS_PRECED:    reg_rdata <= {24'h0, preced};
        OFS_TMR_EN:    reg_rdata <= {24'h0, tmr_en};
        OFS_IDLE1:     reg_rdata <= tval[0];
        OFS_IDLE2:     reg_rdata <= tval[1];
        OFS_IDLE3:     reg_rdata <= tval[2];
        OFS_STBY_SHAL: reg_rdata <= tval[3];
        OFS_STBY_DEEP: reg_rdata <= tval[4];
        OFS_POLICY:    reg_rdata <= {24'h0, policy};
        OFS_IRQ_STAT:  reg_rdata <= {29'h0, irq_stat};
        OFS_IRQ_EN:    reg_rdata <= {29'h0, irq_en};
        OFS_UNLOADS:   reg_rdata <= {25'h0, unloads};
        default:       reg_rdata <= 32'h0;  // unmapped reads zero
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // =====================================================================
  // timers
  // =====================================================================
  pct_tick u_tick (
    .clk    (clk),
    .arst_n (arst_n),
    .tick   (tick)
  );

  // idle1 has the short floor, the other four the long one
  for (genvar i = 0; i < NUM_TMR; i++) begin : g_tmr
    pct_timer u_tmr (
      .clk      (clk),
      .arst_n   (arst_n),
      .enable   (en_vec[i]),
      .init_val (tval[i]),
      .min_val  ((i == 0) ? MIN_IDLE1_TICKS : MIN_OTHER_TICKS),
      .activity (host_activity),
      .tick     (tick),
      .expire   (expire[i])
    );
  end

  assign any_exp = |expire;

  // =====================================================================
  // head unload budget over a fixed day window
  // =====================================================================
  assign unload_ok = (unloads < MAX_UNLOADS);

  // unloads come from idle2, idle3 and both standby timers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      unloads     <= 7'h0;
      win_cnt     <= 32'h0;
      head_unload <= 1'b0;
    end else begin
      head_unload <= 1'b0;
      if (tick && win_cnt == 32'(WINDOW_TICKS - 1)) begin
        win_cnt <= 32'h0;
        unloads <= 7'h0;  // window restarts; fixed windows, not sliding
      end else begin
        if (tick) begin
          win_cnt <= win_cnt + 32'h1;
        end
        if ((|expire[4:1]) && unload_ok && pw != PW_BG) begin
          unloads     <= unloads + 7'h1;
          head_unload <= 1'b1;
        end
      end
    end
  end

  // =====================================================================
  // power state and background precedence
  // =====================================================================
  // except under code 10, expiries during background work wait for it to finish
  // a single expire pulse would otherwise be lost in the busy state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_exp <= 5'h0;
    end else if (pw != PW_BG || host_activity) begin
      pend_exp <= 5'h0;  // activity reloads timers, nothing owed
    end else begin
      pend_exp <= pend_exp | expire;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pw            <= PW_ACTIVE;
      enter_request <= 5'h0;
      bg_run        <= 1'b0;
      bg_suspend    <= 1'b0;
    end else begin
      bg_suspend    <= 1'b0;
      enter_request <= 5'h0;
      unique case (pw)
        PW_ACTIVE: begin
          if (bg_request) begin
            pw     <= PW_BG;
            bg_run <= 1'b1;
          end else if (any_exp) begin
            pw            <= PW_LOW;
            enter_request <= expire;
          end
        end
        PW_LOW: begin
          if (host_activity) begin
            pw <= PW_ACTIVE;
          end else if (bg_request && prec != PREC_LP) begin
            pw     <= PW_BG;  // wake for background
            bg_run <= 1'b1;
          end else if (any_exp) begin
            enter_request <= expire;  // deeper condition
          end
          // code 10: stays low regardless of background
        end
        PW_BG: begin
          if (any_exp && prec == PREC_LP) begin
            bg_suspend    <= 1'b1;
            bg_run        <= 1'b0;
            pw            <= PW_LOW;
            enter_request <= expire;
          end else if (bg_done) begin
            // all work done before any transition
            bg_run <= 1'b0;
            if ((pend_exp | expire) != 5'h0) begin
              pw            <= PW_LOW;  // held expiry taken now
              enter_request <= pend_exp | expire;
            end else begin
              pw <= PW_ACTIVE;
            end
          end
        end
        default: pw <= PW_ACTIVE;
      endcase
    end
  end

  // =====================================================================
  // check condition reporting
  // =====================================================================
  assign ccf_policy.report_idle = (policy[POS_REPORT_AFTER_IDLE_EXIT +: 2] == CCF_ON);
  assign ccf_policy.report_stby = (policy[POS_CCF_STBY +: 2] == CCF_ON);
  assign ccf_policy.report_stop = (policy[POS_CCF_STOP +: 2] == CCF_ON);

  // one pulse when a reportable exit happens; 00 and 11 never report
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      check_condition <= 1'b0;
    end else begin
      check_condition <= (power_exit_idle && ccf_policy.report_idle)
                       | (power_exit_stby && ccf_policy.report_stby)
                       | (power_exit_stop && ccf_policy.report_stop);
    end
  end

  // =====================================================================
  // interrupts: sticky status, set beats clear
  // =====================================================================
  assign ev      = {check_condition, (|expire[4:1]) & ~unload_ok, any_exp};
  assign irq_clr = (reg_wr && reg_addr == OFS_IRQ_CLR) ? reg_wdata[2:0] : 3'h0;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat <= 3'h0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | ev;
    end
  end

  assign irq = |(irq_stat & irq_en);
endmodule : pct_top

// ==== tb/pct_top_properties.sv ====
`timescale 1ns/1ps
// ====================================================================
// port checker for the power condition timers
// ====================================================================
module pct_top_properties
  import pct_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        arst_n,
  // register port
  input wire logic [5:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // unit side
  input wire logic        host_activity,
  input wire logic        bg_request,
  input wire logic        bg_done,
  input wire logic        power_exit_idle,
  input wire logic        power_exit_stby,
  input wire logic        power_exit_stop,
  // requests
  input wire logic [4:0]  enter_request,
  input wire logic        head_unload,
  input wire logic        bg_run,
  input wire logic        bg_suspend,
  input wire logic        check_condition,
  input wire pct_ccf_s    ccf_policy,
  input wire logic        irq
);
  // shortest legal wait before any timer can run out, in clock cycles
  localparam longint IDLE1_CYC = longint'(MIN_IDLE1_TICKS) * TICK_CYC;
  localparam longint OTHER_CYC = longint'(MIN_OTHER_TICKS) * TICK_CYC;
  logic [39:0] age;  // cycles since reset, saturating so it never wraps
  // age counter
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      age <= 40'h0;
    end else if (age != 40'hff_ffff_ffff) begin
      age <= age + 40'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  AST_RDATA_QUIET: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data seen outside its answer cycle");
  AST_CC_IDLE: assert property (
    power_exit_idle && ccf_policy.report_idle |=> check_condition)
    else $error("idle exit report missing");
  AST_CC_STBY: assert property (
    power_exit_stby && ccf_policy.report_stby |=> check_condition)
    else $error("standby exit report missing");
  AST_CC_STOP: assert property (
    power_exit_stop && ccf_policy.report_stop |=> check_condition)
    else $error("stop exit report missing");
  AST_CC_CAUSE: assert property (
    check_condition |-> ($past(power_exit_idle) && $past(ccf_policy.report_idle))
      || ($past(power_exit_stby) && $past(ccf_policy.report_stby))
      || ($past(power_exit_stop) && $past(ccf_policy.report_stop)))
    else $error("report without an enabled exit");
  AST_ENTER_GAP: assert property (
    enter_request != 5'h0 |=> (enter_request == 5'h0) [*8])
    else $error("power request not a lone pulse");
  AST_ENTER_FLOOR: assert property (enter_request != 5'h0 |-> age >= IDLE1_CYC)
    else $error("power request before the one second floor");
  AST_UNLOAD_FLOOR: assert property (head_unload |-> age >= OTHER_CYC)
    else $error("unload before the two minute floor");
  AST_UNLOAD_PULSE: assert property (head_unload |=> !head_unload)
    else $error("unload held longer than one cycle");
  AST_SUSPEND: assert property (bg_suspend |-> $past(bg_run))
    else $error("suspend without background running");
endmodule : pct_top_properties

bind pct_top pct_top_properties chk_u (.clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .host_activity, .bg_request, .bg_done, .power_exit_idle, .power_exit_stby,
  .power_exit_stop, .enter_request, .head_unload, .bg_run, .bg_suspend, .check_condition,
  .ccf_policy, .irq);

// ==== tb/pct_unit_model.sv ====
`timescale 1ns/1ps
// ====================================================================
// unit side model: exits, activity and background work
// ====================================================================
module pct_unit_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // commands from the bench
  input  wire logic [2:0] exit_cmd,
  input  wire logic       act_cmd,
  input  wire logic       bg_cmd,
  input  wire logic       bg_run,
  // toward the block
  output logic            host_activity,
  output logic            bg_request,
  output logic            bg_done,
  output logic            power_exit_idle,
  output logic            power_exit_stby,
  output logic            power_exit_stop
);
  logic [2:0] run_cnt;  // background work takes a few cycles, never instant
  // registered outputs, one cycle behind the commands
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {power_exit_stop, power_exit_stby, power_exit_idle} <= 3'h0;
      host_activity <= 1'b0;
      bg_request    <= 1'b0;
      bg_done       <= 1'b0;
      run_cnt       <= 3'h0;
    end else begin
      {power_exit_stop, power_exit_stby, power_exit_idle} <= exit_cmd;
      host_activity <= act_cmd;
      bg_request    <= bg_cmd;
      run_cnt       <= bg_run ? run_cnt + 3'h1 : 3'h0;
      bg_done       <= (run_cnt == 3'h4);
    end
  end
endmodule : pct_unit_model

// ==== tb/pct_top_tb_top.sv ====
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
  checks_done++; \
  if ((got) !== (ex)) begin \
    errors++; \
    $display("BAD %s exp %h got %h", nm, ex, got); \
  end \
end
// ====================================================================
// bench for the power condition timers
// ====================================================================
module pct_top_tb_top;
  import pct_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0;
  logic [5:0]  reg_addr = 6'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_val;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, act, bgq, bgd, ex_i, ex_s, ex_p;
  logic [2:0]  exit_cmd = 3'h0;
  logic        act_cmd = 1'b0, bg_cmd = 1'b0, head_unload, bg_run, bg_suspend, cc, irq, seen;
  logic [4:0]  enter_request;
  pct_ccf_s    ccf_policy;
  int          errors = 0, checks_done = 0, cyc = 0;
  // reset image of the page and the local status and unload registers
  logic [5:0]  ra [12] = '{OFS_HEADER, OFS_LENGTH, OFS_PRECED, OFS_TMR_EN, OFS_IDLE1,
    OFS_STBY_SHAL, OFS_IDLE2, OFS_IDLE3, OFS_STBY_DEEP, OFS_POLICY, OFS_IRQ_STAT, OFS_UNLOADS};
  logic [31:0] rv [12] = '{32'h1a, 32'h26, 32'h0, 32'h06, 32'h14, 32'h0, 32'h1770, 32'h0,
    32'h0, 32'h58, 32'h0, 32'h0};
  always #2 clk = ~clk;
  pct_top dut_u (.clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .host_activity(act), .bg_request(bgq), .bg_done(bgd), .power_exit_idle(ex_i),
    .power_exit_stby(ex_s), .power_exit_stop(ex_p), .enter_request, .head_unload, .bg_run,
    .bg_suspend, .check_condition(cc), .ccf_policy, .irq);
  pct_unit_model unit_u (.clk, .arst_n, .exit_cmd, .act_cmd, .bg_cmd, .bg_run,
    .host_activity(act), .bg_request(bgq), .bg_done(bgd), .power_exit_idle(ex_i),
    .power_exit_stby(ex_s), .power_exit_stop(ex_p));
  // one write cycle
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // one read cycle; data taken in the answer cycle only
  task automatic rd(input logic [5:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask : rd
  // pulse one exit and watch for the status report over a short window
  task automatic exit_pulse(input int e);
    @(posedge clk);
    exit_cmd <= 3'(1 << e);
    @(posedge clk);
    exit_cmd <= 3'h0;
    seen = 1'b0;
    repeat (4) begin
      @(posedge clk);
      #1 seen = seen | (cc === 1'b1);
    end
  endtask : exit_pulse
  // verdict
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  // hang guard, the run needs about two hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      close_out();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    // reset image
    foreach (ra[i]) begin
      rd(ra[i]);
      `CHK("reset", rv[i], rd_val)
    end
    `CHK("ccf reset", 3'b001, ccf_policy)
    // short values accepted as written, floor applies only to the count
    wr(OFS_IDLE1, 32'h3);
    wr(OFS_IDLE2, 32'h5);
    wr(OFS_STBY_DEEP, 32'h4af);
    rd(OFS_IDLE1);
    `CHK("idle1", 32'h3, rd_val)
    rd(OFS_IDLE2);
    `CHK("idle2", 32'h5, rd_val)
    rd(OFS_STBY_DEEP);
    `CHK("deep", 32'h4af, rd_val)
    // savable flag is the only writable bit of the header
    wr(OFS_HEADER, 32'h80);
    rd(OFS_HEADER);
    `CHK("savable", 32'h9a, rd_val)
    // byte 3 enables off with activity, then code 10 with deep standby enabled and background started
    wr(OFS_TMR_EN, 32'h0);
    rd(OFS_TMR_EN);
    `CHK("enables", 32'h0, rd_val)
    @(posedge clk) act_cmd <= 1'b1;
    @(posedge clk) act_cmd <= 1'b0;
    wr(OFS_PRECED, 32'h81);
    rd(OFS_PRECED);
    `CHK("preced", 32'h81, rd_val)
    @(posedge clk) bg_cmd <= 1'b1;
    repeat (3) @(posedge clk);
    #1 `CHK("bg run", 1'b1, bg_run)
    repeat (9) @(posedge clk);
    bg_cmd <= 1'b0;
    // read-only length and an unmapped place
    wr(OFS_LENGTH, 32'h0);
    wr(6'h3c, 32'hffff_ffff);
    rd(OFS_LENGTH);
    `CHK("length", 32'h26, rd_val)
    `CHK("bg idle", 1'b0, bg_run)
    rd(6'h3c);
    `CHK("unmapped", 32'h0, rd_val)
    // every code of the three report fields against every exit
    for (int c = 0; c < 4; c++) begin
      wr(OFS_POLICY, 32'({2'(c), 2'(c), 2'(c), 2'b00}));
      #1 `CHK("ccf", {3{c == 2}}, ccf_policy)
      for (int e = 0; e < 3; e++) begin
        exit_pulse(e);
        `CHK("report", c == 2, seen)
      end
    end
    // report raises a sticky status, enabled to the interrupt
    wr(OFS_IRQ_CLR, 32'h7);
    wr(OFS_IRQ_EN, 32'h4);
    rd(OFS_IRQ_EN);
    `CHK("irq en", 32'h4, rd_val)
    wr(OFS_POLICY, 32'ha8);
    exit_pulse(0);
    `CHK("irq set", 1'b1, irq)
    rd(OFS_IRQ_STAT);
    `CHK("stat", 32'h4, rd_val & 32'h4)
    wr(OFS_IRQ_CLR, 32'h4);
    #1 `CHK("irq clr", 1'b0, irq)
    wr(OFS_IRQ_EN, 32'h0);
    exit_pulse(2);
    `CHK("irq masked", 1'b0, irq)
    rd(OFS_IRQ_STAT);
    `CHK("stat masked", 32'h4, rd_val & 32'h4)
    wr(OFS_IRQ_CLR, 32'h4);
    rd(OFS_IRQ_STAT);
    `CHK("stat clr", 32'h0, rd_val & 32'h4)
    // far below the one second floor nothing may have expired
    `CHK("no expiry", 7'h0, {enter_request, head_unload, bg_suspend})
    close_out();
  end
endmodule : pct_top_tb_top
